//--- design/modem_pins.sv
// modem handshake, user outputs and host interrupt pin logic
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - status bit 5 shows the present data-set-ready level
// - status bit 1 sets when data-set-ready changed since last status read
// - enabled modem status change raises a host interrupt
// - terminal-ready pin goes low when its control bit is set
// - terminal-ready pin high on master reset, loop mode or bit clear
// - interrupt output high while an enabled cause awaits service
// - four causes: rx error, rx data or timeout, tx empty, modem change
// - interrupt output drops once serviced and on master reset
// - master reset clears registers and sets outputs to reset levels
// - user outputs go low when their control bits are set
// - user outputs high on master reset, loop mode or bit 2/3 clear
// - receiver timing comes from the dedicated 16x receiver clock pin
module modem_pins
   import modem_pins_pkg::*;
#(
   parameter int SYNC_STAGES = SYNC_DEPTH
) (
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  reset,
   // register port
   input  wire logic [ADDR_WIDTH-1:0] addr,
   input  wire logic [DATA_WIDTH-1:0] wdata,
   input  wire logic                  wr,
   input  wire logic                  rd,
   output logic      [DATA_WIDTH-1:0] rdata,
   // cause pulses from transmitter and receiver
   input  wire logic                  cause_rx_data,
   input  wire logic                  cause_tx_empty,
   input  wire logic                  cause_rx_error,
   // pins
   input  wire logic                  master_reset_in,
   input  wire logic                  dsr_n,
   input  wire logic                  receiver_clock_in,
   output logic                       dtr_n,
   output logic                       user_output_one_n,
   output logic                       user_output_two_n,
   output logic                       host_interrupt_out,
   // receiver timing
   output logic                       rx_sample_tick
);

   if (SYNC_STAGES < 2) begin : g_bad_stages
      $error("modem_pins needs at least two synchroniser stages");
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic          dsr_n_level;
   logic          dsr_n_change;
   logic          mr_level;
   logic          rclk_rise;
   bus_req_type   req;
   irq_cause_type cause;

   // data-set-ready idles high: reset there, or release looks like a change
   pin_sync_edge #(.STAGES(SYNC_STAGES), .RESET_LEVEL(1'b1)) u_sync_dsr (
      .clk_sys (clk_sys),
      .reset   (reset),
      .pin     (dsr_n),
      .level   (dsr_n_level),
      .rise    (),
      .change  (dsr_n_change)
   );

   pin_sync_edge #(.STAGES(SYNC_STAGES)) u_sync_mr (
      .clk_sys (clk_sys),
      .reset   (reset),
      .pin     (master_reset_in),
      .level   (mr_level),
      .rise    (),
      .change  ()
   );

   // sampled as a plain input; rate must stay well under clk_sys / 2
   pin_sync_edge #(.STAGES(SYNC_STAGES)) u_sync_rclk (
      .clk_sys (clk_sys),
      .reset   (reset),
      .pin     (receiver_clock_in),
      .level   (),
      .rise    (rclk_rise),
      .change  ()
   );

   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   // ----------------------------------------------------------------
   // control and status state
   // ----------------------------------------------------------------
   mcr_type                  modem_control_register;
   mcr_type                  next_mcr;
   logic [IRQ_COUNT-1:0]     irq_mask;
   logic [IRQ_COUNT-1:0]     next_irq_mask;
   logic [IRQ_COUNT-1:0]     irq_stat;
   logic [IRQ_COUNT-1:0]     next_irq_stat;
   logic                     dsr_delta;
   logic                     next_dsr_delta;
   logic                     dsr_active;
   logic                     dsr_event;
   logic                     msr_read;
   logic [DATA_WIDTH-1:0]    next_rdata;
   logic                     next_dtr_n;
   logic                     next_user_one_n;
   logic                     next_user_two_n;
   logic                     next_interrupt;
   logic                     next_tick;

   always_comb begin
      msr_read   = req.rd && (req.addr == ADDR_MSR);
      // in loop mode the terminal-ready bit stands in for the pin
      dsr_active = modem_control_register.loop_mode ? modem_control_register.terminal_ready : ~dsr_n_level;
      dsr_event  = modem_control_register.loop_mode ? (next_mcr.terminal_ready != modem_control_register.terminal_ready)
                                 : dsr_n_change;
      cause.rx_data      = cause_rx_data;
      cause.tx_empty     = cause_tx_empty;
      cause.rx_error     = cause_rx_error;
      cause.modem_change = dsr_event;
   end

   // ----------------------------------------------------------------
   // next register values
   // ----------------------------------------------------------------
   always_comb begin
      next_mcr       = modem_control_register;
      next_irq_mask  = irq_mask;
      next_irq_stat  = irq_stat;
      next_dsr_delta = dsr_delta;
      if (req.wr && req.addr == ADDR_MCR) begin
         next_mcr = mcr_type'(req.wdata);
      end
      if (req.wr && req.addr == ADDR_IRQ_MASK) begin
         next_irq_mask = req.wdata[IRQ_COUNT-1:0];
      end
      // servicing: write one to clear, modem cause also by status read
      if (req.wr && req.addr == ADDR_IRQ_STAT) begin
         next_irq_stat = next_irq_stat & ~req.wdata[IRQ_COUNT-1:0];
      end
      if (msr_read) begin
         next_dsr_delta           = 1'b0;
         next_irq_stat[IRQ_MODEM] = 1'b0;
      end
      // a new event in the clearing cycle wins
      if (dsr_event) begin
         next_dsr_delta = 1'b1;
      end
      next_irq_stat = next_irq_stat | irq_cause_type'(cause);
      if (mr_level) begin
         next_mcr       = mcr_type'(MCR_RESET);
         next_irq_mask  = IRQ_RESET;
         next_irq_stat  = IRQ_RESET;
         next_dsr_delta = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // next output values
   // ----------------------------------------------------------------
   always_comb begin
      next_rdata = READ_ZERO;
      if (req.rd) begin
         case (req.addr)
            ADDR_MCR: begin
               next_rdata = modem_control_register;
            end
            ADDR_MSR: begin
               next_rdata[MSR_DSR_LEVEL] = dsr_active;
               next_rdata[MSR_DSR_DELTA] = dsr_delta;
            end
            ADDR_IRQ_MASK: begin
               next_rdata[IRQ_COUNT-1:0] = irq_mask;
            end
            ADDR_IRQ_STAT: begin
               next_rdata[IRQ_COUNT-1:0] = irq_stat;
            end
            default: begin
               next_rdata = READ_ZERO;
            end
         endcase
      end
      // loop mode keeps the modem pins quiet for self test
      next_dtr_n      = ~(next_mcr.terminal_ready & ~next_mcr.loop_mode);
      next_user_one_n = ~(next_mcr.user_one & ~next_mcr.loop_mode);
      next_user_two_n = ~(next_mcr.user_two & ~next_mcr.loop_mode);
      next_interrupt  = |(next_irq_stat & next_irq_mask);
      next_tick       = rclk_rise & ~mr_level;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         modem_control_register                <= mcr_type'(MCR_RESET);
         irq_mask           <= IRQ_RESET;
         irq_stat           <= IRQ_RESET;
         dsr_delta          <= 1'b0;
         rdata              <= READ_ZERO;
         dtr_n              <= 1'b1;
         user_output_one_n  <= 1'b1;
         user_output_two_n  <= 1'b1;
         host_interrupt_out <= 1'b0;
         rx_sample_tick     <= 1'b0;
      end else begin
         modem_control_register                <= next_mcr;
         irq_mask           <= next_irq_mask;
         irq_stat           <= next_irq_stat;
         dsr_delta          <= next_dsr_delta;
         rdata              <= next_rdata;
         dtr_n              <= next_dtr_n;
         user_output_one_n  <= next_user_one_n;
         user_output_two_n  <= next_user_two_n;
         host_interrupt_out <= next_interrupt;
         rx_sample_tick     <= next_tick;
      end
   end

endmodule
`default_nettype wire

//--- design/pin_sync_edge.sv
// pin synchroniser with level and edge outputs
`timescale 1ns/1ns
`default_nettype none
module pin_sync_edge #(
   parameter int   STAGES      = 2,
   parameter logic RESET_LEVEL = 1'b0
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic reset,
   // pin side
   input  wire logic pin,
   // synchronous side
   output logic      level,
   output logic      rise,
   output logic      change
);

   // ----------------------------------------------------------------
   // synchroniser chain
   // ----------------------------------------------------------------
   logic [STAGES-1:0] chain;
   logic [STAGES-1:0] next_chain;
   logic              prev;

   if (STAGES < 2) begin : g_bad_stages
      $error("pin_sync_edge needs at least two stages");
   end

   always_comb begin
      next_chain = {chain[STAGES-2:0], pin};
   end

   // start at the pin's idle level so release shows no false edge
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         chain <= {STAGES{RESET_LEVEL}};
         prev  <= RESET_LEVEL;
      end else begin
         chain <= next_chain;
         prev  <= chain[STAGES-1];
      end
   end

   // only the last stage and its delayed copy feed logic
   assign level  = chain[STAGES-1];
   assign rise   = chain[STAGES-1] & ~prev;
   assign change = chain[STAGES-1] ^ prev;

endmodule
`default_nettype wire

//--- pkg/modem_pins_pkg.sv
// constants and carriers for the modem handshake and interrupt pin block
package modem_pins_pkg;

   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam int          ADDR_WIDTH    = 3;
   localparam int          DATA_WIDTH    = 8;
   localparam logic [2:0]  ADDR_IRQ_MASK = 3'h1;
   localparam logic [2:0]  ADDR_IRQ_STAT = 3'h2;
   localparam logic [2:0]  ADDR_MCR      = 3'h4;
   localparam logic [2:0]  ADDR_MSR      = 3'h6;

   // ----------------------------------------------------------------
   // modem status field positions
   // ----------------------------------------------------------------
   localparam int          MSR_DSR_DELTA = 1;
   localparam int          MSR_DSR_LEVEL = 5;

   // ----------------------------------------------------------------
   // interrupt cause positions (status and mask share the layout)
   // ----------------------------------------------------------------
   localparam int          IRQ_RX_DATA   = 0;
   localparam int          IRQ_TX_EMPTY  = 1;
   localparam int          IRQ_RX_ERROR  = 2;
   localparam int          IRQ_MODEM     = 3;
   localparam int          IRQ_COUNT     = 4;

   // ----------------------------------------------------------------
   // reset values and default synchroniser depth
   // ----------------------------------------------------------------
   localparam logic [7:0]  MCR_RESET     = 8'h00;
   localparam logic [3:0]  IRQ_RESET     = 4'h0;
   localparam logic [7:0]  READ_ZERO     = 8'h00;
   localparam int          SYNC_DEPTH    = 2;

   // modem control register layout
   typedef struct packed {
      logic [2:0] spare;
      logic       loop_mode;
      logic       user_two;
      logic       user_one;
      logic       request_send;
      logic       terminal_ready;
   } mcr_type;

   // one-cycle cause pulses from the transmitter, the receiver and the modem status change
   typedef struct packed {
      logic       modem_change;
      logic       rx_error;
      logic       tx_empty;
      logic       rx_data;
   } irq_cause_type;

   // register bus request
   typedef struct packed {
      logic [ADDR_WIDTH-1:0] addr;
      logic [DATA_WIDTH-1:0] wdata;
      logic                  wr;
      logic                  rd;
   } bus_req_type;

endpackage

//--- verification/modem_model.sv
// far side model: data set ready line and receiver clock source
`timescale 1ns/1ns
`default_nettype none
module modem_model #(
   parameter int HALF_NS = 40
) (
   // pins toward the block
   output logic dsr_n,
   output logic receiver_clock_in
);
   // --------------------------------------------------------------
   // looped 16x clock, free running, phase unrelated to clk_sys
   // --------------------------------------------------------------
   initial begin
      dsr_n = 1'b1;
      receiver_clock_in = 1'b0;
      #3;
      forever #HALF_NS receiver_clock_in = ~receiver_clock_in;
   end
   // modem answers after its own delay, off the system clock
   task automatic set_ready(input logic on, input int dly);
      #(dly) dsr_n = !on;
   endtask
endmodule
`default_nettype wire

//--- verification/modem_pins_checker.sv
// port assertions for the modem pin block
`timescale 1ns/1ns
`default_nettype none
module modem_pins_checker
   import modem_pins_pkg::*;
#(
   parameter int SYNC_STAGES = SYNC_DEPTH
) (
   // clock, reset and register port
   input wire logic                  clk_sys,
   input wire logic                  reset,
   input wire logic [ADDR_WIDTH-1:0] addr,
   input wire logic [DATA_WIDTH-1:0] wdata,
   input wire logic                  wr,
   input wire logic                  rd,
   input wire logic [DATA_WIDTH-1:0] rdata,
   // causes and pins
   input wire logic                  cause_rx_data,
   input wire logic                  cause_tx_empty,
   input wire logic                  cause_rx_error,
   input wire logic                  master_reset_in,
   input wire logic                  dsr_n,
   input wire logic                  receiver_clock_in,
   input wire logic                  dtr_n,
   input wire logic                  user_output_one_n,
   input wire logic                  user_output_two_n,
   input wire logic                  host_interrupt_out,
   input wire logic                  rx_sample_tick
);
   // --------------------------------------------------------------
   // helpers: master reset quiet time, age of last pin change
   // --------------------------------------------------------------
   logic [3:0] quiet_cnt;
   logic [3:0] dsr_age;
   logic       dsr_prev;
   logic       loop_on;
   wire logic  quiet  = quiet_cnt > 4'(SYNC_STAGES + 1);
   wire logic  mcr_wr = wr && addr == ADDR_MCR && quiet;
   wire logic  msr_rd = rd && addr == ADDR_MSR;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         quiet_cnt <= 4'h0;
         dsr_age   <= 4'hF;
         dsr_prev  <= 1'b1;
         loop_on   <= 1'b0;
      end else begin
         quiet_cnt <= master_reset_in ? 4'h0 : quiet_cnt + 4'(quiet_cnt != 4'hF);
         dsr_prev  <= dsr_n;
         dsr_age   <= (dsr_n != dsr_prev) ? 4'h0 : dsr_age + 4'(dsr_age != 4'hF);
         loop_on   <= mcr_wr ? wdata[4] : (loop_on && quiet);
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   // --------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------
   dtr_pin_a: assert property (
         mcr_wr |=> dtr_n == !($past(wdata[0]) && !$past(wdata[4])))
      else $error("terminal ready pin wrong after control write");
   user_one_a: assert property (
         mcr_wr |=> user_output_one_n == !($past(wdata[2]) && !$past(wdata[4])))
      else $error("user output one wrong after control write");
   user_two_a: assert property (
         mcr_wr |=> user_output_two_n == !($past(wdata[3]) && !$past(wdata[4])))
      else $error("user output two wrong after control write");
   mr_pins_a: assert property (
         master_reset_in [*4] |=> dtr_n && user_output_one_n && user_output_two_n
                                  && !host_interrupt_out)
      else $error("pins not at reset levels under master reset");
   irq_rise_a: assert property (
         $rose(host_interrupt_out) |-> dsr_age inside {[1:8]}
            || $past(cause_rx_data || cause_tx_empty || cause_rx_error || wr))
      else $error("interrupt rose without a cause");
   irq_fall_a: assert property (
         $fell(host_interrupt_out) |-> $past(wr) || $past(rd) || $past(rd, 2) || !quiet)
      else $error("interrupt dropped without service");
   // compare with the pin as it stood at the read, not one cycle later
   dsr_level_a: assert property (
         msr_rd && dsr_age > 4'h6 && !loop_on |=> rdata[MSR_DSR_LEVEL] == !$past(dsr_n))
      else $error("ready level bit does not follow pin");
   delta_clear_a: assert property (
         msr_rd ##2 (msr_rd && dsr_age > 4'h6 && !loop_on) |=> !rdata[MSR_DSR_DELTA])
      else $error("change flag not cleared by status read");
   // master reset suppresses the tick, so only edges well clear of it count
   tick_a: assert property (
         $rose(receiver_clock_in) && quiet && !master_reset_in |-> ##[1:4] rx_sample_tick)
      else $error("no receiver tick after receiver clock edge");
   cover property (msr_rd ##1 rdata[MSR_DSR_DELTA]);
   cover property ($rose(host_interrupt_out));
   cover property (master_reset_in [*4]);
endmodule
bind modem_pins modem_pins_checker #(.SYNC_STAGES(SYNC_STAGES)) u_modem_pins_checker (.*);
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the modem pin block
`timescale 1ns/1ns
`default_nettype none
module tb;
   import modem_pins_pkg::*;
   logic                  clk_sys = 1'b0;
   logic                  reset = 1'b1;
   logic [ADDR_WIDTH-1:0] addr = '0;
   logic [DATA_WIDTH-1:0] wdata = '0;
   logic                  wr = 1'b0;
   logic                  rd = 1'b0;
   irq_cause_type         cause = '0;
   logic                  master_reset_in = 1'b0;
   logic [DATA_WIDTH-1:0] rdata;
   logic                  dsr_n, rclk, dtr_n, one_n, two_n, irq;
   logic                  rd_seen = 1'b0;
   logic [15:0]           notes[$];
   logic [15:0]           note;
   logic [7:0]            w;
   logic [7:0]            exp_pins;
   int                    num_errors = 0;
   int                    samples_checked = 0;
   always #5 clk_sys = ~clk_sys;
   modem_model u_modem_model (.dsr_n(dsr_n), .receiver_clock_in(rclk));
   modem_pins u_modem_pins (.clk_sys(clk_sys), .reset(reset), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .cause_rx_data(cause.rx_data),
      .cause_tx_empty(cause.tx_empty), .cause_rx_error(cause.rx_error),
      .master_reset_in(master_reset_in), .dsr_n(dsr_n), .receiver_clock_in(rclk),
      .dtr_n(dtr_n), .user_output_one_n(one_n), .user_output_two_n(two_n),
      .host_interrupt_out(irq), .rx_sample_tick());
   // --------------------------------------------------------------
   // compare, bus cycles, read data monitor
   // --------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // read notes {care mask, expected}; a zero mask discards the answer
   task automatic bus(input logic w_on, input logic [2:0] a, input logic [7:0] d,
                      input logic [7:0] care);
      wr <= w_on;
      rd <= !w_on;
      addr <= a;
      wdata <= d;
      if (!w_on) notes.push_back({care, d});
      @(posedge clk_sys);
   endtask
   task automatic idle(input int n, input logic [3:0] c = 4'h0);
      wr <= 1'b0;
      rd <= 1'b0;
      cause <= irq_cause_type'(c);
      repeat (n) @(posedge clk_sys);
   endtask
   always @(posedge clk_sys) begin
      rd_seen <= rd;
      if (rd_seen) begin
         note = notes.pop_front();
         check(rdata & note[15:8], note[7:0] & note[15:8]);
      end
   end
   task automatic stop_test();
      if (num_errors == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      #100000;
      num_errors++;
      stop_test();
   end
   // --------------------------------------------------------------
   // scenarios
   // --------------------------------------------------------------
   initial begin
      void'($urandom(32'h4D4C));
      repeat (12) @(posedge clk_sys);
      reset <= 1'b0;
      idle(6);
      check({4'h0, dtr_n, one_n, two_n, irq}, 8'h0E);
      for (int a = 0; a < 8; a++) bus(1'b0, 3'(a), 8'h00, 8'hFF);
      for (int i = 0; i < 8; i++) begin
         w = (i < 2) ? {3'h0, i[0], 4'hD} : 8'($urandom);
         exp_pins = {5'h0, !(w[0] && !w[4]), !(w[2] && !w[4]), !(w[3] && !w[4])};
         bus(1'b1, ADDR_MCR, w, 8'h00);
         bus(1'b0, ADDR_MCR, w, 8'hFF);
         idle(1);
         check({5'h0, dtr_n, one_n, two_n}, exp_pins);
      end
      // loop mode: status follows the terminal-ready bit, a toggle is a change
      bus(1'b1, ADDR_MCR, 8'h10, 8'h00);
      bus(1'b1, ADDR_MCR, 8'h11, 8'h00);
      bus(1'b0, ADDR_MSR, 8'h22, 8'hFF);
      bus(1'b1, ADDR_MCR, 8'h00, 8'h00);
      idle(6);
      bus(1'b0, ADDR_MSR, 8'h00, 8'h00);
      bus(1'b1, ADDR_IRQ_STAT, 8'h0F, 8'h00);
      bus(1'b1, ADDR_IRQ_MASK, 8'h07, 8'h00);
      for (int i = 0; i < 3; i++) begin
         idle(1, 4'(1 << i));
         idle(1);
         check({7'h0, irq}, 8'h01);
         bus(1'b0, ADDR_IRQ_STAT, 8'(1 << i), 8'hFF);
         bus(1'b1, ADDR_IRQ_STAT, 8'(1 << i), 8'h00);
         idle(2);
         check({7'h0, irq}, 8'h00);
      end
      // masked cause waits in status until enabled
      bus(1'b1, ADDR_IRQ_MASK, 8'h00, 8'h00);
      idle(1, 4'h4);
      idle(2);
      check({7'h0, irq}, 8'h00);
      bus(1'b0, ADDR_IRQ_STAT, 8'h04, 8'hFF);
      bus(1'b1, ADDR_IRQ_MASK, 8'h0C, 8'h00);
      idle(2);
      check({7'h0, irq}, 8'h01);
      bus(1'b1, ADDR_IRQ_STAT, 8'h04, 8'h00);
      bus(1'b1, ADDR_IRQ_MASK, 8'h08, 8'h00);
      idle(2);
      check({7'h0, irq}, 8'h00);
      u_modem_model.set_ready(1'b1, 3);
      idle(8);
      check({7'h0, irq}, 8'h01);
      bus(1'b0, ADDR_MSR, 8'h22, 8'hFF);
      idle(1);
      bus(1'b0, ADDR_MSR, 8'h20, 8'hFF);
      idle(2);
      check({7'h0, irq}, 8'h00);
      u_modem_model.set_ready(1'b0, 3);
      idle(8);
      bus(1'b0, ADDR_MSR, 8'h02, 8'hFF);
      bus(1'b1, ADDR_IRQ_STAT, 8'h08, 8'h00);
      bus(1'b1, ADDR_MCR, 8'h0D, 8'h00);
      bus(1'b1, ADDR_IRQ_MASK, 8'h0F, 8'h00);
      idle(1, 4'h2);
      master_reset_in <= 1'b1;
      idle(1);
      check({7'h0, irq}, 8'h01);
      idle(3);
      bus(1'b1, ADDR_MCR, 8'h0D, 8'h00);
      idle(2);
      check({4'h0, dtr_n, one_n, two_n, irq}, 8'h0E);
      master_reset_in <= 1'b0;
      idle(6);
      bus(1'b0, ADDR_MCR, 8'h00, 8'hFF);
      bus(1'b0, ADDR_IRQ_MASK, 8'h00, 8'hFF);
      bus(1'b0, ADDR_IRQ_STAT, 8'h00, 8'hFF);
      idle(3);
      stop_test();
   end
endmodule
`default_nettype wire
